/* event_mask_reg.sv */
// event enable mask register with rounding of fractional writes
`timescale 1ns/1ps
`default_nettype none
`include "load_comp_consts.svh"
module event_mask_reg #(
  parameter int MASK_IN_W = 20
) (
  input  wire logic                 clk_sys,
  input  wire logic                 rst_n,
  input  wire logic                 writeEn,
  input  wire logic [MASK_IN_W-1:0] writeValue,
  input  wire logic [7:0]           eventStatus,
  output logic                      writeReject,
  output logic [7:0]                mask,
  output logic                      eventSummary
);
  import load_comp_pkg::*;

  typedef struct packed {
    logic [7:0] mask;
    logic       summary;
  } mask_state_t;

  localparam int INT_W = MASK_IN_W - `LC_FRAC_BITS;

  mask_state_t st;
  mask_state_t next_st;
  logic [INT_W:0] rounded;

  always_comb begin
    // half of the last integer step rounds up
    rounded = {1'b0, writeValue[MASK_IN_W-1:`LC_FRAC_BITS]}
              + {{INT_W{1'b0}}, writeValue[`LC_FRAC_BITS-1]};
    writeReject = rounded > {{(INT_W-7){1'b0}}, `LC_MASK_MAX};
    next_st = st;
    if (writeEn && !writeReject) begin
      next_st.mask = rounded[7:0];
    end
    // unused positions never raise the summary even if written
    next_st.summary = |(eventStatus & st.mask & `LC_MASK_USED);
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st <= '{mask: `LC_MASK_RESET, summary: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign mask         = st.mask;
  assign eventSummary = st.summary;

  a_mask_write_round: assert property (@(posedge clk_sys) disable iff (!rst_n)
    writeEn && !writeReject |=> mask == $past(rounded[7:0]))
    else $error("mask did not take rounded value");
  a_mask_reject_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
    writeEn && writeReject |=> $stable(mask))
    else $error("rejected mask write changed mask");
  a_summary_gated_used: assert property (@(posedge clk_sys) disable iff (!rst_n)
    eventSummary |-> |($past(eventStatus) & $past(mask) & `LC_MASK_USED))
    else $error("summary raised without enabled flag");
endmodule
`default_nettype wire

/* host_model.sv */
// controller-side model: issues commands and collects answer items
`timescale 1ns/1ps
`default_nettype none
module host_model
  import load_comp_pkg::*;
(
  input  wire logic                             clk_sys,
  input  wire logic                             cmdReady,
  input  wire logic                             respValid,
  input  wire load_comp_pkg::item_fmt_t         respFormat,
  input  wire logic [load_comp_pkg::VALUE_W-1:0] respData,
  input  wire logic                             respLast,
  output logic                                  cmdValid,
  output load_comp_pkg::cmd_op_t                cmdOp,
  output logic [2:0]                            cmdGroup,
  output load_comp_pkg::ref_mode_t              cmdMode,
  output logic [load_comp_pkg::VALUE_W-1:0]     cmdRef1,
  output logic                                  cmdRef1Off,
  output logic [load_comp_pkg::VALUE_W-1:0]     cmdRef2,
  output logic                                  cmdRef2Off,
  output logic                                  cmdRef2Fixed,
  output logic [19:0]                           cmdMaskValue,
  output logic                                  respReady
);
  item_fmt_t    fmt [4];
  logic [31:0]  dat [4];
  logic         lst [4];
  initial begin
    cmdValid = 1'b0;
    respReady = 1'b0;
  end
  // caller stands at a falling edge; fields held until the accepting edge
  task send(input cmd_op_t op, input logic [2:0] g, input ref_mode_t m, input logic [31:0] r1, input logic [31:0] r2,
            input logic [2:0] off, input logic [19:0] mv);
    // a stuck handshake is left to the bench watchdog
    cmdOp = op;
    cmdGroup = g;
    cmdMode = m;
    cmdRef1 = r1;
    cmdRef2 = r2;
    cmdMaskValue = mv;
    {cmdRef1Off, cmdRef2Off, cmdRef2Fixed} = off;
    cmdValid = 1'b1;
    while (cmdReady !== 1'b1) begin
      @(negedge clk_sys);
    end
    @(negedge clk_sys);
  endtask
  // only status traffic while compensation runs is the caller's duty
  task quiet;
    cmdValid = 1'b0;
  endtask
  // stall gives a slow consumer; an item is taken at the edge after it is recorded
  task get(input int n, input int stall);
    for (int i = 0; i < n; i++) begin
      if (stall > 0) begin
        respReady = 1'b0;
        repeat (stall) @(negedge clk_sys);
      end
      respReady = 1'b1;
      while (respValid !== 1'b1) begin
        @(negedge clk_sys);
      end
      fmt[i] = respFormat;
      dat[i] = respData;
      lst[i] = respLast;
      @(negedge clk_sys);
    end
    respReady = 1'b0;
  endtask
endmodule
`default_nettype wire

/* load_comp_consts.svh */
// constants for load-compensation reference and event mask handling
`ifndef LOAD_COMP_CONSTS_SVH
`define LOAD_COMP_CONSTS_SVH
`define LC_GROUPS      5
`define LC_GROUP_MIN   3'h1
`define LC_GROUP_MAX   3'h5
`define LC_MASK_RESET  8'h00
`define LC_MASK_USED   8'h7B
`define LC_MASK_MAX    8'hFF
`define LC_FRAC_BITS   8
`define LC_ITEM_FIRST  2'h0
`define LC_ITEM_MODE   2'h1
`define LC_ITEM_REF1   2'h2
`define LC_ITEM_REF2   2'h3
`define LC_ITEM_MONI   2'h1
`endif

/* load_comp_pkg.sv */
// types for load-compensation reference and event mask handling
package load_comp_pkg;
  localparam int VALUE_W = 32;

  typedef enum logic [2:0] {
    OP_SET_REF    = 3'h0,
    OP_QUERY_REF  = 3'h1,
    OP_QUERY_MON  = 3'h2,
    OP_SET_MASK   = 3'h3,
    OP_QUERY_MASK = 3'h4
  } cmd_op_t;

  typedef enum logic [2:0] {
    MODE_OFF          = 3'h0,
    MODE_IMPEDANCE    = 3'h1,
    MODE_SERIES_CAP   = 3'h2,
    MODE_PARALLEL_CAP = 3'h3,
    MODE_SERIES_IND   = 3'h4,
    MODE_PARALLEL_IND = 3'h5,
    MODE_SERIES_RES   = 3'h6
  } ref_mode_t;

  typedef enum logic [2:0] {
    FMT_INT   = 3'h0,
    FMT_FIXED = 3'h1,
    FMT_EXP   = 3'h2,
    FMT_MODE  = 3'h3,
    FMT_OFF   = 3'h4
  } item_fmt_t;

  typedef struct packed {
    ref_mode_t          mode;
    logic               ref1Set;
    logic               ref2Set;
    logic               ref2Fixed;
    logic [VALUE_W-1:0] ref1;
    logic [VALUE_W-1:0] ref2;
  } group_t;

  typedef struct packed {
    item_fmt_t          fmt;
    logic [VALUE_W-1:0] data;
    logic               last;
  } item_t;
endpackage

/* load_comp_ref.sv */
// command handler for load-compensation references, monitor query and event mask
// How it works
// - five reference groups are kept, picked by a group index from one to five.
// - each group's mode tells which parameter pair its two reference values stand for, or none.
// - a reference query answers group index, mode, first value, second value, in that order.
// - any unset mode or reference value is answered as the word OFF.
// - the first value goes out in exponent form, the second in fixed or exponent form, either may be OFF.
// - the monitor query answers voltage in fixed form, then current in exponent form.
// - a mask write takes an integer from zero to 255 as the eight-bit enable mask.
// - a fractional mask value is rounded to an integer before it is stored.
// - the mask clears to zero at power-on.
// - a mask query returns the stored integer; bits 7 and 2 enable nothing.
// - while compensation runs, reference setting commands are refused with an execution error; mask writes are still taken.
`timescale 1ns/1ps
`default_nettype none
`include "load_comp_consts.svh"
module load_comp_ref #(
  parameter int MASK_IN_W = 20
) (
  input  wire logic                                clk_sys,
  input  wire logic                                rst_n,
  input  wire logic                                cmdValid,
  output logic                                     cmdReady,
  input  wire load_comp_pkg::cmd_op_t              cmdOp,
  input  wire logic [2:0]                          cmdGroup,
  input  wire load_comp_pkg::ref_mode_t            cmdMode,
  input  wire logic [load_comp_pkg::VALUE_W-1:0]   cmdRef1,
  input  wire logic                                cmdRef1Off,
  input  wire logic [load_comp_pkg::VALUE_W-1:0]   cmdRef2,
  input  wire logic                                cmdRef2Off,
  input  wire logic                                cmdRef2Fixed,
  input  wire logic [MASK_IN_W-1:0]                cmdMaskValue,
  input  wire logic                                compRunning,
  input  wire logic [load_comp_pkg::VALUE_W-1:0]   monVoltage,
  input  wire logic [load_comp_pkg::VALUE_W-1:0]   monCurrent,
  input  wire logic [7:0]                          eventStatus,
  output logic                                     cmdError,
  output logic                                     respValid,
  input  wire logic                                respReady,
  output load_comp_pkg::item_fmt_t                 respFormat,
  output logic [load_comp_pkg::VALUE_W-1:0]        respData,
  output logic                                     respLast,
  output logic [7:0]                               eventMask,
  output logic                                     eventSummary
);
  import load_comp_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RESP = 2'b10
  } state_t;

  typedef struct packed {
    state_t                   state;
    cmd_op_t                  op;
    logic [1:0]               idx;
    logic [2:0]               grp;
    logic [VALUE_W-1:0]       monI;
    item_t                    item;
    logic                     error;
    group_t [`LC_GROUPS-1:0]  groups;
  } ctrl_state_t;

  ctrl_state_t st;
  ctrl_state_t next_st;
  logic        accept;
  logic        maskWrite;
  logic        maskReject;
  logic [2:0]  slot;

  function automatic logic groupOk(input logic [2:0] g);
    return (g >= `LC_GROUP_MIN) && (g <= `LC_GROUP_MAX);
  endfunction

  // one answer item for query op at position idx
  function automatic item_t itemFor(input cmd_op_t op, input logic [1:0] idx, input logic [2:0] g,
                                    input group_t grp, input logic [VALUE_W-1:0] monV,
                                    input logic [VALUE_W-1:0] monI, input logic [7:0] msk);
    item_t it;
    it = '{fmt: FMT_INT, data: '0, last: 1'b0};
    unique case (op)
      OP_QUERY_REF: begin
        it.last = idx == `LC_ITEM_REF2;
        unique case (idx)
          `LC_ITEM_FIRST: it.data = {{(VALUE_W-3){1'b0}}, g};
          `LC_ITEM_MODE: begin
            it.fmt  = grp.mode == MODE_OFF ? FMT_OFF : FMT_MODE;
            it.data = {{(VALUE_W-3){1'b0}}, grp.mode};
          end
          `LC_ITEM_REF1: begin
            it.fmt  = grp.ref1Set ? FMT_EXP : FMT_OFF;
            it.data = grp.ref1Set ? grp.ref1 : '0;
          end
          default: begin
            it.fmt  = !grp.ref2Set ? FMT_OFF : (grp.ref2Fixed ? FMT_FIXED : FMT_EXP);
            it.data = grp.ref2Set ? grp.ref2 : '0;
          end
        endcase
      end
      OP_QUERY_MON: begin
        it.fmt  = idx == `LC_ITEM_FIRST ? FMT_FIXED : FMT_EXP;
        it.data = idx == `LC_ITEM_FIRST ? monV : monI;
        it.last = idx == `LC_ITEM_MONI;
      end
      default: begin
        it.data = {{(VALUE_W-8){1'b0}}, msk};
        it.last = 1'b1;
      end
    endcase
    return it;
  endfunction

  assign cmdReady  = st.state == ST_IDLE;
  assign accept    = cmdValid && cmdReady;
  assign maskWrite = accept && cmdOp == OP_SET_MASK;
  assign slot      = cmdGroup - `LC_GROUP_MIN;

  always_comb begin
    next_st       = st;
    next_st.error = 1'b0;
    unique case (st.state)
      ST_IDLE: begin
        if (accept) begin
          next_st.op  = cmdOp;
          next_st.grp = cmdGroup;
          next_st.idx = `LC_ITEM_FIRST;
          unique case (cmdOp)
            OP_SET_REF: begin
              // queries stay open during compensation so status can be polled
              if (compRunning || !groupOk(cmdGroup)) begin
                next_st.error = 1'b1;
              end else begin
                next_st.groups[slot].mode      = cmdMode;
                next_st.groups[slot].ref1      = cmdRef1;
                next_st.groups[slot].ref2      = cmdRef2;
                next_st.groups[slot].ref2Fixed = cmdRef2Fixed;
                next_st.groups[slot].ref1Set   = !cmdRef1Off && cmdMode != MODE_OFF;
                next_st.groups[slot].ref2Set   = !cmdRef2Off && cmdMode != MODE_OFF;
              end
            end
            OP_SET_MASK: begin
              next_st.error = maskReject;
            end
            OP_QUERY_REF: begin
              if (!groupOk(cmdGroup)) begin
                next_st.error = 1'b1;
              end else begin
                next_st.state = ST_RESP;
                next_st.item  = itemFor(cmdOp, `LC_ITEM_FIRST, cmdGroup, st.groups[slot],
                                        monVoltage, monCurrent, eventMask);
              end
            end
            OP_QUERY_MON: begin
              // both values captured together so the pair is coherent
              next_st.monI  = monCurrent;
              next_st.state = ST_RESP;
              next_st.item  = itemFor(cmdOp, `LC_ITEM_FIRST, cmdGroup, st.groups[slot],
                                      monVoltage, monCurrent, eventMask);
            end
            OP_QUERY_MASK: begin
              next_st.state = ST_RESP;
              next_st.item  = itemFor(cmdOp, `LC_ITEM_FIRST, cmdGroup, st.groups[slot],
                                      monVoltage, monCurrent, eventMask);
            end
            default: begin
              next_st.error = 1'b1;
            end
          endcase
        end
      end
      ST_RESP: begin
        if (respReady) begin
          if (st.item.last) begin
            next_st.state = ST_IDLE;
          end else begin
            next_st.idx  = st.idx + 2'h1;
            next_st.item = itemFor(st.op, st.idx + 2'h1, st.grp, st.groups[st.grp - `LC_GROUP_MIN],
                                   st.monI, st.monI, eventMask);
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st       <= '0;
      st.state <= ST_IDLE;
    end else begin
      st <= next_st;
    end
  end

  event_mask_reg #(.MASK_IN_W(MASK_IN_W)) u_mask (
    .clk_sys      (clk_sys),
    .rst_n        (rst_n),
    .writeEn      (maskWrite),
    .writeValue   (cmdMaskValue),
    .eventStatus  (eventStatus),
    .writeReject  (maskReject),
    .mask         (eventMask),
    .eventSummary (eventSummary)
  );

  assign respValid  = st.state == ST_RESP;
  assign respFormat = st.item.fmt;
  assign respData   = st.item.data;
  assign respLast   = st.item.last;
  assign cmdError   = st.error;

  sequence s_ref_query;
    accept && cmdOp == OP_QUERY_REF && groupOk(cmdGroup);
  endsequence
  sequence s_mon_query;
    accept && cmdOp == OP_QUERY_MON;
  endsequence
  sequence s_mon_first_taken;
    respValid && respReady && st.op == OP_QUERY_MON && respFormat == FMT_FIXED && !respLast;
  endsequence

  a_busy_set_refused: assert property (@(posedge clk_sys) disable iff (!rst_n)
    accept && cmdOp == OP_SET_REF && compRunning |=> cmdError && $stable(st.groups))
    else $error("set during compensation not refused");
  a_bad_group_error: assert property (@(posedge clk_sys) disable iff (!rst_n)
    accept && (cmdOp == OP_QUERY_REF || cmdOp == OP_SET_REF) && !groupOk(cmdGroup) |=> cmdError && !respValid)
    else $error("bad group index accepted");
  a_ref_first_group: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_ref_query |=> respValid && respFormat == FMT_INT && respData == VALUE_W'($past(cmdGroup)))
    else $error("reference answer does not open with group");
  a_ref_last_fourth: assert property (@(posedge clk_sys) disable iff (!rst_n)
    respValid && st.op == OP_QUERY_REF |-> respLast == (st.idx == `LC_ITEM_REF2))
    else $error("reference answer not four items");
  a_ref1_exp_off: assert property (@(posedge clk_sys) disable iff (!rst_n)
    respValid && st.op == OP_QUERY_REF && st.idx == `LC_ITEM_REF1 |-> respFormat inside {FMT_EXP, FMT_OFF})
    else $error("first reference not exponent or OFF");
  a_mode_off_unset: assert property (@(posedge clk_sys) disable iff (!rst_n)
    accept && cmdOp == OP_SET_REF && cmdMode == MODE_OFF && !compRunning && groupOk(cmdGroup)
    |=> !st.groups[$past(slot)].ref1Set && !st.groups[$past(slot)].ref2Set)
    else $error("mode OFF left values set");
  a_mon_order: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_mon_query |=> respValid && respFormat == FMT_FIXED && !respLast)
    else $error("monitor answer does not open with voltage");
  a_mon_current_last: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_mon_first_taken |=> respValid && respFormat == FMT_EXP && respLast)
    else $error("monitor answer does not close with current");
  a_mask_query_value: assert property (@(posedge clk_sys) disable iff (!rst_n)
    accept && cmdOp == OP_QUERY_MASK |=> respLast && respData == VALUE_W'($past(eventMask)))
    else $error("mask query value wrong");
endmodule
`default_nettype wire

/* load_comp_ref_tb.sv */
// self-checking bench for the load-compensation command handler
`timescale 1ns/1ps
`default_nettype none
module load_comp_ref_tb;
  import load_comp_pkg::*;
  logic                clk_sys, rst_n, cmdValid, cmdReady, cmdRef1Off, cmdRef2Off, cmdRef2Fixed, compRunning;
  logic                cmdError, respValid, respReady, respLast, eventSummary;
  cmd_op_t             cmdOp;
  ref_mode_t           cmdMode;
  item_fmt_t           respFormat;
  logic [2:0]          cmdGroup;
  logic [19:0]         cmdMaskValue;
  logic [7:0]          eventStatus, eventMask;
  logic [VALUE_W-1:0]  cmdRef1, cmdRef2, monVoltage, monCurrent, respData;
  int                  n_errors, checks, me;
  logic [19:0]         mv [5] = '{20'h01499, 20'h01466, 20'h00080, 20'h0FF00, 20'h0FF80};
  logic [7:0]          em [5] = '{8'h15, 8'h14, 8'h01, 8'hFF, 8'hFF};
  always #50 clk_sys = ~clk_sys;
  load_comp_ref u_dut (.clk_sys, .rst_n, .cmdValid, .cmdReady, .cmdOp, .cmdGroup, .cmdMode, .cmdRef1,
    .cmdRef1Off, .cmdRef2, .cmdRef2Off, .cmdRef2Fixed, .cmdMaskValue, .compRunning, .monVoltage, .monCurrent,
    .eventStatus, .cmdError, .respValid, .respReady, .respFormat, .respData, .respLast, .eventMask, .eventSummary);
  host_model u_host (.clk_sys, .cmdReady, .respValid, .respFormat, .respData, .respLast, .cmdValid, .cmdOp,
    .cmdGroup, .cmdMode, .cmdRef1, .cmdRef1Off, .cmdRef2, .cmdRef2Off, .cmdRef2Fixed, .cmdMaskValue, .respReady);
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  task item(input int i, input item_fmt_t f, input logic [31:0] d, input logic l);
    check({29'h0, u_host.fmt[i]}, {29'h0, f});
    check(u_host.dat[i], d);
    check({31'h0, u_host.lst[i]}, {31'h0, l});
  endtask
  task sref(input logic [2:0] g, input ref_mode_t m, input logic [31:0] r1, input logic [31:0] r2, input logic [2:0] o);
    u_host.send(OP_SET_REF, g, m, r1, r2, o, 20'h0);
  endtask
  task qref(input logic [2:0] g, input int stall);
    u_host.send(OP_QUERY_REF, g, MODE_OFF, 0, 0, 3'h0, 20'h0);
    u_host.quiet();
    u_host.get(4, stall);
    item(0, FMT_INT, {29'h0, g}, 1'b0);
  endtask
  task end_of_test;
    $display("checks %0d, mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    #(3000 * 100);
    n_errors++;
    $display("unexpected at %0t: run did not finish", $time);
    end_of_test();
  end
  initial begin
    {clk_sys, rst_n, compRunning, eventStatus, monVoltage, monCurrent} = '0;
    n_errors = 0;
    checks = 0;
    repeat (10) @(negedge clk_sys);
    rst_n = 1'b1;
    check(32'(eventMask), 0);
    check({31'h0, cmdReady}, 1);
    u_host.send(OP_QUERY_MASK, 3'h1, MODE_OFF, 0, 0, 3'h0, 20'h0);
    u_host.quiet();
    u_host.get(1, 0);
    item(0, FMT_INT, 0, 1'b1);
    qref(3'h3, 0);
    item(1, FMT_OFF, 0, 1'b0);
    item(2, FMT_OFF, 0, 1'b0);
    item(3, FMT_OFF, 0, 1'b1);
    $display("test reset values done");
    // back-to-back writes; group 1 is written twice so the later write is seen to win
    for (int m = 1; m <= 6; m++) sref(3'((m - 1) % 5 + 1), ref_mode_t'(m), m << 4, m << 8, 3'b000);
    u_host.quiet();
    for (int g = 1; g <= 5; g++) begin
      me = (g == 1) ? 6 : g;
      qref(3'(g), g % 3);
      item(1, FMT_MODE, me, 1'b0);
      item(2, FMT_EXP, me << 4, 1'b0);
      item(3, FMT_EXP, me << 8, 1'b1);
    end
    sref(3'h0, MODE_IMPEDANCE, 1, 1, 3'b000);
    check({31'h0, cmdError}, 1);
    u_host.send(OP_QUERY_REF, 3'h6, MODE_OFF, 0, 0, 3'h0, 20'h0);
    check({31'h0, cmdError}, 1);
    u_host.quiet();
    @(negedge clk_sys);
    check({31'h0, respValid}, 0);
    $display("test groups and modes done");
    sref(3'h3, MODE_OFF, 32'h11, 32'h22, 3'b001);
    sref(3'h4, MODE_SERIES_RES, 5, 7, 3'b101);
    u_host.quiet();
    qref(3'h3, 0);
    item(1, FMT_OFF, 0, 1'b0);
    item(2, FMT_OFF, 0, 1'b0);
    item(3, FMT_OFF, 0, 1'b1);
    qref(3'h4, 1);
    item(1, FMT_MODE, 6, 1'b0);
    item(2, FMT_OFF, 0, 1'b0);
    item(3, FMT_FIXED, 7, 1'b1);
    $display("test unset values done");
    // group 2 was configured before compensation starts
    compRunning = 1'b1;
    sref(3'h2, MODE_IMPEDANCE, 1, 1, 3'b000);
    check({31'h0, cmdError}, 1);
    u_host.quiet();
    qref(3'h2, 0);
    item(1, FMT_MODE, 2, 1'b0);
    item(2, FMT_EXP, 32'h20, 1'b0);
    $display("test busy refusal done");
    // half-up rounding, top of range, and an over-range refusal that keeps the old mask
    for (int i = 0; i < 5; i++) begin
      u_host.send(OP_SET_MASK, 3'h1, MODE_OFF, 0, 0, 3'h0, mv[i]);
      check({31'h0, cmdError}, (i == 4) ? 1 : 0);
      check(32'(eventMask), 32'(em[i]));
    end
    compRunning = 1'b0;
    u_host.send(OP_QUERY_MASK, 3'h1, MODE_OFF, 0, 0, 3'h0, 20'h0);
    u_host.quiet();
    u_host.get(1, 2);
    item(0, FMT_INT, 255, 1'b1);
    eventStatus = 8'h84;
    repeat (2) @(negedge clk_sys);
    check({31'h0, eventSummary}, 0);
    eventStatus = 8'h40;
    repeat (2) @(negedge clk_sys);
    check({31'h0, eventSummary}, 1);
    // a second reset must clear the mask again
    rst_n = 1'b0;
    @(negedge clk_sys);
    rst_n = 1'b1;
    check(32'(eventMask), 0);
    check({31'h0, eventSummary}, 0);
    $display("test event mask done");
    monVoltage = 32'h0000_1234;
    monCurrent = 32'hABCD_0001;
    u_host.send(OP_QUERY_MON, 3'h1, MODE_OFF, 0, 0, 3'h0, 20'h0);
    u_host.quiet();
    // values change after accept; the answer must keep what was captured
    monVoltage = 32'h0;
    monCurrent = 32'h0;
    u_host.get(2, 1);
    item(0, FMT_FIXED, 32'h0000_1234, 1'b0);
    item(1, FMT_EXP, 32'hABCD_0001, 1'b1);
    $display("test monitor query done");
    end_of_test();
  end
endmodule
`default_nettype wire
